// [pkg/ssp_pkg.sv]
package ssp_pkg;
	// ****************
	// register map
	// ****************
	localparam logic [2:0] A_CTRL = 3'h0;
	localparam logic [2:0] A_FMT  = 3'h1;
	localparam logic [2:0] A_PIN  = 3'h2;
	localparam logic [2:0] A_EN   = 3'h3;
	localparam logic [2:0] A_STAT = 3'h4;
	localparam logic [2:0] A_TXD  = 3'h5;
	localparam logic [2:0] A_RXD  = 3'h6;

	// ****************
	// reset values and counts
	// ****************
	localparam logic [4:0] RST_CTRL    = 5'h00;
	localparam logic [2:0] RST_FMT     = 3'h0;
	localparam logic [3:0] RST_PIN     = 4'h0;
	localparam logic [4:0] RST_EN      = 5'h00;
	localparam logic [3:0] RST_STAT    = 4'h1;
	localparam logic [4:0] FRAME_EDGES = 5'h10;
	localparam logic [7:0] HALF_BASE   = 8'h02;
	localparam logic [2:0] DIV_MAX_SEL = 3'h6;
	localparam logic [1:0] CS_MST_OUT  = 2'h2;
	localparam logic [1:0] CS_SLV_IN   = 2'h1;

	// ****************
	// synchroniser slots
	// ****************
	localparam int SYNC_N = 4;
	localparam int SY_IN  = 0;
	localparam int SY_OUT = 1;
	localparam int SY_SCK = 2;
	localparam int SY_CS  = 3;

	// ****************
	// register layouts
	// ****************
	typedef struct packed {
		logic [2:0] div_sel;
		logic       rx_stop_after_frame;
		logic       clock_role_sel;
	} ssp_ctrl_s;

	typedef struct packed {
		logic lsb_first_sel;
		logic clk_idle_level;
		logic clk_phase_sel;
	} ssp_fmt_s;

	typedef struct packed {
		logic cs_func_hi;
		logic cs_func_lo;
		logic half_duplex_sel;
		logic four_wire_sel;
	} ssp_pin_s;

	typedef struct packed {
		logic rx_irq_en;
		logic tx_done_irq_en;
		logic tx_empty_irq_en;
		logic rx_enable;
		logic tx_enable;
	} ssp_en_s;

	typedef struct packed {
		logic overrun_flag;
		logic rx_buf_full;
		logic tx_done;
		logic tx_buf_empty;
	} ssp_stat_s;

	typedef struct packed {
		logic o;
		logic oe_n;
	} ssp_pad_s;
endpackage : ssp_pkg

// [design/ssp_core.sv]
// Behaviour
// [R01] txd write clears empty, loads shifter, sets empty again, starts shifting
// [R02] empty flag with its enable raises the transmit-empty request
// [R03] pending tx word at frame end is loaded and sent at once
// [R04] frame ends with tx buffer empty: set transmit-done
// [R05] transmit-done with its enable raises the transmit-done request
// [R06] after transmission the clock pin rests at the idle level
// [R07] no transmit while overrun set; software clears it first
// [R08] master drives own clock on pin; slave shifts on pin clock
// [R09] master: dummy rxd read starts the receive clock
// [R10] eighth bit in: store word, set full, raise request if enabled
// [R11] reading rxd clears the receive-full flag
// [R12] stop bit ends master reception after the current frame
// [R13] master rxd read with receive enabled restarts the clock
// [R14] frame completes while full: set overrun and halt
// [R15] no receive while overrun set; software clears it first
// [R16] clearing receive enable keeps full, overrun and rxd
// [R17] software clears both enables before changing mode or format
// [R18] combined mode starts on txd write, ends empty, stops on overrun
// [R19] software enters combined mode with flags clear, both enables at once
// [R20] half-duplex: software never enables transmit and receive together
// [R21] half-duplex uses out pin both ways; in pin left alone
// [R22] four-wire select pin: 10b master output, 01b slave input
// [R23] four-wire mode is normally used msb first
// [R24] all enabled sources merge into one request
// [R25] master clock is bus clock divided by four up to 256
// [R26] eight-bit frames, edges chosen by phase and idle level
//
// Implementation choices: the register offsets and the plain strobed port.
`timescale 1ns/10ps
`default_nettype none

module ssp_core (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic [2:0]  addr,
	input  wire logic [7:0]  wdata,
	input  wire logic        wr,
	input  wire logic        rd,
	output logic [7:0]       rdata,
	input  wire logic        serial_clk_pin_i,
	output ssp_pkg::ssp_pad_s serial_clk_pin_o,
	input  wire logic        serial_in_pin_i,
	output ssp_pkg::ssp_pad_s serial_in_pin_o,
	input  wire logic        serial_out_pin_i,
	output ssp_pkg::ssp_pad_s serial_out_pin_o,
	input  wire logic        chip_sel_pin_i,
	output ssp_pkg::ssp_pad_s chip_sel_pin_o,
	output logic             irq,
	output logic             tx_empty_irq,
	output logic             tx_done_irq,
	output logic             rx_full_irq
);
	// ****************
	// helpers
	// ****************
	function automatic logic ssp_sel(input logic [2:0] a,
		input logic [2:0] k, input logic s);
		return s && (a == k);
	endfunction : ssp_sel

	function automatic logic ssp_head(input logic [7:0] v, input logic l);
		return l ? v[0] : v[7];
	endfunction : ssp_head

	function automatic logic [7:0] ssp_shout(input logic [7:0] v,
		input logic l);
		return l ? {1'b0, v[7:1]} : {v[6:0], 1'b0};
	endfunction : ssp_shout

	function automatic logic [7:0] ssp_shin(input logic [7:0] v,
		input logic b, input logic l);
		return l ? {b, v[7:1]} : {v[6:0], b};
	endfunction : ssp_shin

	// ****************
	// state
	// ****************
	ssp_pkg::ssp_ctrl_s ctrl_r;
	ssp_pkg::ssp_fmt_s  fmt_r;
	ssp_pkg::ssp_pin_s  pin_r;
	ssp_pkg::ssp_en_s   en_r;
	ssp_pkg::ssp_stat_s stat_r;
	ssp_pkg::ssp_en_s   wen;
	ssp_pkg::ssp_stat_s wst;
	logic [7:0] tdr_r, rdr_r, tsr_r, rsr_r, div_cnt_r, half;
	logic [4:0] edge_cnt_r;
	logic [ssp_pkg::SYNC_N-1:0] sy1_r, sy2_r;
	logic       tsr_full_r, busy_r, sck_r, dout_r, sck_d_r;
	logic       master, hdx, swap, ovr, cs_s, cs_ok, s_arm, run;
	logic       wr_txd, rd_rxd, wr_stat, wr_en, tx_en_rise;
	logic       m_tick, s_lead, edge_ev, lead, samp, launch, last, din;
	logic       ovr_set, store, chain_ld, idle_ld, ld, rx_start, rx_cont;
	logic       done_set, drv_ok, cs_drv;
	logic [7:0] rx_word;

	// ****************
	// decode
	// ****************
	assign master  = ctrl_r.clock_role_sel;
	assign hdx     = pin_r.four_wire_sel & pin_r.half_duplex_sel;
	assign swap    = pin_r.four_wire_sel & ~pin_r.half_duplex_sel & ~master;
	assign ovr     = stat_r.overrun_flag;
	assign wr_txd  = ssp_sel(addr, ssp_pkg::A_TXD, wr);
	assign rd_rxd  = ssp_sel(addr, ssp_pkg::A_RXD, rd);
	assign wr_stat = ssp_sel(addr, ssp_pkg::A_STAT, wr);
	assign wr_en   = ssp_sel(addr, ssp_pkg::A_EN, wr);
	assign wen     = wdata[4:0];
	assign wst     = wdata[3:0];
	assign tx_en_rise = wr_en & wen.tx_enable & ~en_r.tx_enable;

	// ****************
	// pin synchronisers
	// ****************
	genvar gi;
	for (gi = 0; gi < ssp_pkg::SYNC_N; gi++) begin : g_sync
		logic pin;
		if (gi == ssp_pkg::SY_IN) begin : g_in
			assign pin = serial_in_pin_i;
		end else if (gi == ssp_pkg::SY_OUT) begin : g_out
			assign pin = serial_out_pin_i;
		end else if (gi == ssp_pkg::SY_SCK) begin : g_sck
			assign pin = serial_clk_pin_i;
		end else begin : g_cs
			assign pin = chip_sel_pin_i;
		end
		always_ff @(posedge clk or posedge rst) begin
			if (rst) begin
				sy1_r[gi] <= 1'b0;
				sy2_r[gi] <= 1'b0;
			end else begin
				sy1_r[gi] <= pin;
				sy2_r[gi] <= sy1_r[gi];
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			sck_d_r <= 1'b0;
		else
			sck_d_r <= sy2_r[ssp_pkg::SY_SCK];
	end

	// ****************
	// transfer clock and edges
	// ****************
	assign half = ssp_pkg::HALF_BASE << ((ctrl_r.div_sel > ssp_pkg::DIV_MAX_SEL)
		? ssp_pkg::DIV_MAX_SEL : ctrl_r.div_sel); // R25
	assign m_tick = busy_r & master & (div_cnt_r == half - 8'h01); // R25
	assign cs_s  = sy2_r[ssp_pkg::SY_CS];
	assign cs_ok = ~(pin_r.four_wire_sel & ~master & ({pin_r.cs_func_hi,
		pin_r.cs_func_lo} == ssp_pkg::CS_SLV_IN)) | ~cs_s; // R22
	assign s_arm = ~ovr & (tsr_full_r | en_r.rx_enable) & cs_ok; // R15
	assign run   = master ? busy_r : s_arm;
	assign s_lead = sy2_r[ssp_pkg::SY_SCK] != fmt_r.clk_idle_level;
	assign edge_ev = master ? m_tick
		: ((sy2_r[ssp_pkg::SY_SCK] ^ sck_d_r) & s_arm); // R08
	assign lead   = master ? (sck_r == fmt_r.clk_idle_level) : s_lead;
	assign samp   = edge_ev & (lead ^ fmt_r.clk_phase_sel); // R26
	assign launch = edge_ev & ~(lead ^ fmt_r.clk_phase_sel); // R26
	assign last   = edge_ev & (edge_cnt_r == ssp_pkg::FRAME_EDGES - 5'h01);
	assign din    = (hdx | swap) ? sy2_r[ssp_pkg::SY_OUT]
		: sy2_r[ssp_pkg::SY_IN]; // R21

	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			div_cnt_r <= 8'h00;
		else if (!busy_r || m_tick)
			div_cnt_r <= 8'h00;
		else
			div_cnt_r <= div_cnt_r + 8'h01;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			sck_r <= 1'b0;
		else if (!busy_r)
			sck_r <= fmt_r.clk_idle_level; // R06
		else if (m_tick)
			sck_r <= ~sck_r; // R08
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			edge_cnt_r <= 5'h00;
		else if (!run || last)
			edge_cnt_r <= 5'h00;
		else if (edge_ev)
			edge_cnt_r <= edge_cnt_r + 5'h01;
	end

	// ****************
	// frame sequencing
	// ****************
	assign ovr_set  = last & en_r.rx_enable & stat_r.rx_buf_full & ~rd_rxd;
	assign store    = last & en_r.rx_enable & ~ovr_set; // R16
	assign chain_ld = last & en_r.tx_enable & ~stat_r.tx_buf_empty & ~ovr_set
		& ~wr_txd; // R03
	assign idle_ld  = ~tsr_full_r & (master ? ~busy_r : edge_cnt_r == 5'h00)
		& en_r.tx_enable & ~stat_r.tx_buf_empty & ~ovr & ~edge_ev
		& ~wr_txd; // R07
	assign ld       = chain_ld | idle_ld; // R01
	assign rx_start = rd_rxd & master & en_r.rx_enable & ~en_r.tx_enable
		& ~busy_r & ~ovr; // R09 R13
	assign rx_cont  = en_r.rx_enable & ~en_r.tx_enable
		& ~ctrl_r.rx_stop_after_frame & ~ovr_set; // R12
	assign done_set = last & tsr_full_r & stat_r.tx_buf_empty; // R04
	assign rx_word  = samp ? ssp_shin(rsr_r, din, fmt_r.lsb_first_sel) : rsr_r;

	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			busy_r <= 1'b0;
		else if ((idle_ld & master) | rx_start)
			busy_r <= 1'b1; // R18
		else if (last & master)
			busy_r <= chain_ld | rx_cont; // R12 R18
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			tsr_full_r <= 1'b0;
		else if (ld)
			tsr_full_r <= 1'b1;
		else if (last)
			tsr_full_r <= 1'b0;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			tsr_r  <= 8'h00;
			dout_r <= 1'b0;
		end else if (ld) begin
			tsr_r <= fmt_r.clk_phase_sel ? tdr_r
				: ssp_shout(tdr_r, fmt_r.lsb_first_sel); // R26
			if (!fmt_r.clk_phase_sel)
				dout_r <= ssp_head(tdr_r, fmt_r.lsb_first_sel);
		end else if (launch && !last) begin
			dout_r <= ssp_head(tsr_r, fmt_r.lsb_first_sel);
			tsr_r  <= ssp_shout(tsr_r, fmt_r.lsb_first_sel);
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			rsr_r <= 8'h00;
		else if (samp)
			rsr_r <= rx_word;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			rdr_r <= 8'h00;
		else if (store)
			rdr_r <= rx_word; // R10
	end

	// ****************
	// software registers
	// ****************
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ctrl_r <= ssp_pkg::RST_CTRL;
			fmt_r  <= ssp_pkg::RST_FMT;
			pin_r  <= ssp_pkg::RST_PIN;
			en_r   <= ssp_pkg::RST_EN;
			tdr_r  <= 8'h00;
		end else if (wr) begin
			unique case (addr)
				ssp_pkg::A_CTRL: ctrl_r <= wdata[4:0];
				ssp_pkg::A_FMT:  fmt_r  <= wdata[2:0];
				ssp_pkg::A_PIN:  pin_r  <= wdata[3:0];
				ssp_pkg::A_EN:   en_r   <= wen;
				ssp_pkg::A_TXD:  tdr_r  <= wdata;
				default: ;
			endcase
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			stat_r <= ssp_pkg::RST_STAT;
		end else begin
			if (ld | tx_en_rise)
				stat_r.tx_buf_empty <= 1'b1; // R01
			else if (wr_txd)
				stat_r.tx_buf_empty <= 1'b0; // R01
			if (done_set)
				stat_r.tx_done <= 1'b1; // R04
			else if (wr_txd | (wr_stat & ~wst.tx_done))
				stat_r.tx_done <= 1'b0;
			if (store)
				stat_r.rx_buf_full <= 1'b1; // R10
			else if (rd_rxd | (wr_stat & ~wst.rx_buf_full))
				stat_r.rx_buf_full <= 1'b0; // R11
			if (ovr_set)
				stat_r.overrun_flag <= 1'b1; // R14
			else if (wr_stat & ~wst.overrun_flag)
				stat_r.overrun_flag <= 1'b0;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			rdata <= 8'h00;
		else if (rd) begin
			unique case (addr)
				ssp_pkg::A_CTRL: rdata <= {3'h0, ctrl_r};
				ssp_pkg::A_FMT:  rdata <= {5'h00, fmt_r};
				ssp_pkg::A_PIN:  rdata <= {4'h0, pin_r};
				ssp_pkg::A_EN:   rdata <= {3'h0, en_r};
				ssp_pkg::A_STAT: rdata <= {4'h0, stat_r};
				ssp_pkg::A_TXD:  rdata <= tdr_r;
				ssp_pkg::A_RXD:  rdata <= rdr_r;
				default:         rdata <= 8'h00;
			endcase
		end else
			rdata <= 8'h00;
	end

	// ****************
	// requests and pads
	// ****************
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			tx_empty_irq <= 1'b0;
			tx_done_irq  <= 1'b0;
			rx_full_irq  <= 1'b0;
			irq          <= 1'b0;
		end else begin
			tx_empty_irq <= en_r.tx_empty_irq_en & stat_r.tx_buf_empty; // R02
			tx_done_irq  <= en_r.tx_done_irq_en & stat_r.tx_done; // R05
			rx_full_irq  <= en_r.rx_irq_en & stat_r.rx_buf_full; // R10
			irq <= (en_r.tx_empty_irq_en & stat_r.tx_buf_empty)
				| (en_r.tx_done_irq_en & stat_r.tx_done)
				| (en_r.rx_irq_en & (stat_r.rx_buf_full | ovr)); // R24
		end
	end

	assign drv_ok = ~pin_r.four_wire_sel | (master ? busy_r : cs_ok);
	assign cs_drv = pin_r.four_wire_sel & master & ({pin_r.cs_func_hi,
		pin_r.cs_func_lo} == ssp_pkg::CS_MST_OUT); // R22

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			serial_clk_pin_o <= 2'h1;
			serial_out_pin_o <= 2'h1;
			serial_in_pin_o  <= 2'h1;
			chip_sel_pin_o   <= 2'h3;
		end else begin
			serial_clk_pin_o <= '{o: sck_r, oe_n: ~master}; // R08 R06
			serial_out_pin_o <= '{o: dout_r,
				oe_n: ~(en_r.tx_enable & ~swap & drv_ok)}; // R21
			serial_in_pin_o  <= '{o: dout_r,
				oe_n: ~(en_r.tx_enable & swap & drv_ok)}; // R21
			chip_sel_pin_o   <= '{o: ~busy_r, oe_n: ~cs_drv}; // R22
		end
	end

	// ****************
	// checks
	// ****************
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	sequence s_txwr;
		wr_txd && en_r.tx_enable && master && !busy_r && !tsr_full_r
			&& stat_r.tx_buf_empty && !ovr;
	endsequence
	sequence s_reload;
		!stat_r.tx_buf_empty ##1 (stat_r.tx_buf_empty && busy_r);
	endsequence
	property p_tx_write;
		s_txwr ##1 !wr_txd |-> s_reload;
	endproperty
	a_tx_write: assert property (p_tx_write) // R01
		else $error("tx write did not start a frame");

	property p_empty_irq;
		stat_r.tx_buf_empty && en_r.tx_empty_irq_en |=> tx_empty_irq && irq;
	endproperty
	a_empty_irq: assert property (p_empty_irq) // R02
		else $error("missing transmit-empty request");

	property p_chain;
		chain_ld |=> tsr_full_r && stat_r.tx_buf_empty;
	endproperty
	a_chain: assert property (p_chain) // R03
		else $error("pending word not chained");

	property p_done;
		done_set |=> stat_r.tx_done ##1 (tx_done_irq == $past(en_r.tx_done_irq_en)
			|| !stat_r.tx_done);
	endproperty
	a_done: assert property (p_done) // R04
		else $error("transmit-done not set");

	property p_done_irq;
		stat_r.tx_done && en_r.tx_done_irq_en |=> tx_done_irq;
	endproperty
	a_done_irq: assert property (p_done_irq) // R05
		else $error("missing transmit-done request");

	property p_idle_clk;
		(master && !busy_r && $stable(fmt_r))[*3]
			|-> serial_clk_pin_o.o == fmt_r.clk_idle_level
			&& !serial_clk_pin_o.oe_n;
	endproperty
	a_idle_clk: assert property (p_idle_clk) // R06
		else $error("clock pin not at idle level");

	property p_ovr_block;
		ovr |-> !ld && !rx_start && !edge_ev;
	endproperty
	a_ovr_block: assert property (p_ovr_block) // R07
		else $error("transfer started during overrun");

	property p_rx_start;
		rx_start |=> busy_r ##1 (busy_r || last);
	endproperty
	a_rx_start: assert property (p_rx_start) // R09
		else $error("rxd read did not start clock");

	property p_store;
		last && en_r.rx_enable && !stat_r.rx_buf_full |=> stat_r.rx_buf_full
			##1 (rx_full_irq == $past(en_r.rx_irq_en));
	endproperty
	a_store: assert property (p_store) // R10
		else $error("received frame not stored");

	property p_rd_clear;
		rd_rxd && !last |=> !stat_r.rx_buf_full;
	endproperty
	a_rd_clear: assert property (p_rd_clear) // R11
		else $error("rxd read left full set");

	property p_overrun;
		ovr_set |=> stat_r.overrun_flag && !busy_r && $stable(rdr_r);
	endproperty
	a_overrun: assert property (p_overrun) // R14
		else $error("overrun not flagged or not halted");
endmodule : ssp_core

`default_nettype wire

// [verif/ssp_peer.sv]
`timescale 1ns/10ps
`default_nettype none
// ****************
// serial peer facing the clock master
// ****************
module ssp_peer #(
	parameter logic [7:0] BASE = 8'ha6
) (
	input  wire logic sck,
	input  wire logic en,
	input  wire logic hold,
	input  wire logic idle,
	input  wire logic phase,
	input  wire logic mosi,
	output logic      miso
);
	logic [7:0] sh = BASE;
	logic [7:0] rx;
	logic [4:0] e = 5'h00;
	logic [7:0] got[$];

	initial miso = BASE[7];

	always @(sck) begin
		if (en && !hold) begin
			if ((sck != idle) ^ phase) begin
				rx = {rx[6:0], mosi};
			end else if (phase) begin
				miso = sh[7];
				sh = sh << 1;
			end else begin
				sh = sh << 1;
				miso = sh[7];
			end
			e = e + 5'h01;
			if (e == 5'h10) begin
				got.push_back(rx);
				e = 5'h00;
				sh = BASE ^ 8'(got.size());
				miso = phase ? ~miso : sh[7];
			end
		end
	end
endmodule : ssp_peer
`default_nettype wire

// [verif/test_clocked_serial_port_ops.sv]
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin \
	comparisons++; \
	if ((g) !== (e)) begin \
		miscompares++; \
		$display("[FAIL] %s expected %h seen %h", n, e, g); \
	end \
end
module test_clocked_serial_port_ops;
	logic              clk = 1'b0;
	logic              rst = 1'b1;
	logic [2:0]        addr = 3'h0;
	logic [7:0]        wdata = 8'h00;
	logic              wr = 1'b0;
	logic              rd = 1'b0;
	logic              tb_sck = 1'b0;
	logic              tb_cs_n = 1'b1;
	logic              hold = 1'b1;
	logic              p_idle = 1'b0;
	logic              p_phase = 1'b0;
	logic [7:0]        rdata;
	logic [7:0]        v;
	logic              irq, tx_empty_irq, tx_done_irq, rx_full_irq;
	ssp_pkg::ssp_pad_s ck_pad, in_pad, out_pad, cs_pad;
	wire logic         sck_w, miso, in_w, out_w, cs_w;
	int                miscompares = 0;
	int                comparisons = 0;
	int                n0;
	int                n;

	assign sck_w = ck_pad.oe_n ? tb_sck : ck_pad.o;
	assign in_w = in_pad.oe_n ? miso : in_pad.o;
	assign out_w = out_pad.oe_n ? miso : out_pad.o;
	assign cs_w = cs_pad.oe_n ? tb_cs_n : cs_pad.o;

	initial forever #12.5 clk = ~clk;

	ssp_core ssp_core_inst (.clk(clk), .rst(rst), .addr(addr),
		.wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
		.serial_clk_pin_i(sck_w), .serial_clk_pin_o(ck_pad),
		.serial_in_pin_i(in_w), .serial_in_pin_o(in_pad),
		.serial_out_pin_i(out_w), .serial_out_pin_o(out_pad),
		.chip_sel_pin_i(cs_w), .chip_sel_pin_o(cs_pad), .irq(irq),
		.tx_empty_irq(tx_empty_irq), .tx_done_irq(tx_done_irq),
		.rx_full_irq(rx_full_irq));

	ssp_peer ssp_peer_inst (.sck(sck_w), .en(~ck_pad.oe_n), .hold(hold),
		.idle(p_idle), .phase(p_phase), .mosi(out_pad.o), .miso(miso));

	// ****************
	// bus tasks
	// ****************
	task automatic reg_wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask : reg_wr

	task automatic reg_rd(input logic [2:0] a, output logic [7:0] d);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		d = rdata;
	endtask : reg_rd

	task automatic chk_rd(input logic [2:0] a, input logic [7:0] e);
		logic [7:0] d;
		reg_rd(a, d);
		`CHK("read", e, d)
	endtask : chk_rd

	task automatic wait_flag(input int b);
		logic [7:0] d;
		for (int i = 0; i < 2000; i++) begin
			reg_rd(ssp_pkg::A_STAT, d);
			if (d[b] === 1'b1) break;
		end
		`CHK("flag", 1'b1, d[b])
	endtask : wait_flag

	task automatic cfg(input logic [7:0] c, f, p, e);
		hold <= 1'b1;
		reg_wr(ssp_pkg::A_EN, 8'h00);
		reg_wr(ssp_pkg::A_CTRL, c);
		reg_wr(ssp_pkg::A_FMT, f);
		reg_wr(ssp_pkg::A_PIN, p);
		reg_wr(ssp_pkg::A_STAT, 8'h00);
		reg_wr(ssp_pkg::A_EN, e);
		p_idle <= f[1];
		p_phase <= f[0];
		repeat (3) @(posedge clk);
		hold <= 1'b0;
	endtask : cfg

	task automatic half_len(output int c);
		logic s;
		c = 0;
		s = sck_w;
		while (sck_w === s && c < 600) begin
			@(posedge clk);
			#1;
			c++;
		end
		s = sck_w;
		c = 0;
		while (sck_w === s && c < 600) begin
			@(posedge clk);
			#1;
			c++;
		end
	endtask : half_len

	// bench drives the clock as master, samples before each rising edge
	task automatic slave_frame(input logic use_in, output logic [7:0] w);
		w = 8'h00;
		for (int i = 0; i < 16; i++) begin
			repeat (8) @(posedge clk);
			if (!tb_sck)
				w = {w[6:0], use_in ? in_pad.o : out_pad.o};
			tb_sck <= ~tb_sck;
		end
	endtask : slave_frame

	task tally_and_finish;
		if (miscompares == 0 && comparisons > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : tally_and_finish

	initial begin
		#1000000;
		miscompares++;
		tally_and_finish;
	end

	// ****************
	// tests
	// ****************
	initial begin
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		chk_rd(ssp_pkg::A_CTRL, 8'(ssp_pkg::RST_CTRL));
		chk_rd(ssp_pkg::A_FMT, 8'(ssp_pkg::RST_FMT));
		chk_rd(ssp_pkg::A_PIN, 8'(ssp_pkg::RST_PIN));
		chk_rd(ssp_pkg::A_EN, 8'(ssp_pkg::RST_EN));
		chk_rd(ssp_pkg::A_STAT, 8'(ssp_pkg::RST_STAT));
		reg_wr(3'h7, 8'hff);
		chk_rd(3'h7, 8'h00);
		reg_wr(ssp_pkg::A_FMT, 8'h07);
		chk_rd(ssp_pkg::A_FMT, 8'h07);
		`CHK("ck_oe", 1'b1, ck_pad.oe_n)
		for (int d = 0; d < 7; d++) begin
			cfg(8'({d[2:0], 2'b01}), 8'h00, 8'h00, 8'h0d);
			reg_wr(ssp_pkg::A_TXD, 8'h81 + 8'(d));
			half_len(n);
			`CHK("half", 2 << d, n)
			`CHK("txe_irq", 1'b1, tx_empty_irq)
			wait_flag(1);
			`CHK("txd_irq", 1'b1, tx_done_irq)
			`CHK("irq", 1'b1, irq)
			`CHK("peer", 8'h81 + 8'(d), ssp_peer_inst.got[$])
			`CHK("idle", 1'b0, ck_pad.o)
		end
		cfg(8'h01, 8'h00, 8'h00, 8'h01);
		reg_wr(ssp_pkg::A_TXD, 8'h3c);
		reg_wr(ssp_pkg::A_TXD, 8'hc3);
		wait_flag(1);
		`CHK("chain0", 8'h3c, ssp_peer_inst.got[$-1])
		`CHK("chain1", 8'hc3, ssp_peer_inst.got[$])
		for (int f = 1; f < 5; f++) begin
			cfg(8'h01, 8'(f), 8'h00, 8'h01);
			reg_wr(ssp_pkg::A_TXD, 8'h1d);
			wait_flag(1);
			`CHK("fmt", f[2] ? 8'hb8 : 8'h1d, ssp_peer_inst.got[$])
			`CHK("idle", f[1], ck_pad.o)
		end
		cfg(8'h09, 8'h00, 8'h00, 8'h12);
		n0 = ssp_peer_inst.got.size();
		reg_rd(ssp_pkg::A_RXD, v);
		wait_flag(2);
		`CHK("rxf_irq", 1'b1, rx_full_irq)
		reg_wr(ssp_pkg::A_CTRL, 8'h0b);
		chk_rd(ssp_pkg::A_RXD, 8'ha6 ^ 8'(n0));
		reg_rd(ssp_pkg::A_STAT, v);
		`CHK("full_clr", 1'b0, v[2])
		wait_flag(2);
		n = ssp_peer_inst.got.size();
		repeat (200) @(posedge clk);
		`CHK("stopped", n, ssp_peer_inst.got.size())
		reg_wr(ssp_pkg::A_EN, 8'h10);
		chk_rd(ssp_pkg::A_STAT, 8'h05);
		reg_wr(ssp_pkg::A_CTRL, 8'h01);
		chk_rd(ssp_pkg::A_RXD, 8'ha6 ^ 8'(n0 + 1));
		cfg(8'h09, 8'h00, 8'h00, 8'h12);
		reg_rd(ssp_pkg::A_RXD, v);
		wait_flag(3);
		`CHK("ovr_irq", 1'b1, irq)
		n = ssp_peer_inst.got.size();
		repeat (200) @(posedge clk);
		`CHK("halted", n, ssp_peer_inst.got.size())
		reg_wr(ssp_pkg::A_EN, 8'h00);
		reg_wr(ssp_pkg::A_EN, 8'h01);
		chk_rd(ssp_pkg::A_STAT, 8'h0d);
		reg_wr(ssp_pkg::A_TXD, 8'h55);
		repeat (200) @(posedge clk);
		`CHK("no_tx", n, ssp_peer_inst.got.size())
		reg_wr(ssp_pkg::A_STAT, 8'h01);
		wait_flag(1);
		`CHK("tx_after", 8'h55, ssp_peer_inst.got[$])
		cfg(8'h09, 8'h00, 8'h00, 8'h03);
		n = ssp_peer_inst.got.size();
		reg_wr(ssp_pkg::A_TXD, 8'h42);
		wait_flag(1);
		`CHK("both_tx", 8'h42, ssp_peer_inst.got[$])
		chk_rd(ssp_pkg::A_RXD, 8'ha6 ^ 8'(n));
		cfg(8'h01, 8'h00, 8'h09, 8'h01);
		reg_wr(ssp_pkg::A_TXD, 8'hf0);
		repeat (6) @(posedge clk);
		#1;
		`CHK("cs_o", 1'b0, cs_pad.o)
		`CHK("cs_oe", 1'b0, cs_pad.oe_n)
		wait_flag(1);
		cfg(8'h01, 8'h00, 8'h03, 8'h01);
		reg_wr(ssp_pkg::A_TXD, 8'h0f);
		repeat (6) @(posedge clk);
		#1;
		`CHK("in_oe", 1'b1, in_pad.oe_n)
		`CHK("out_oe", 1'b0, out_pad.oe_n)
		wait_flag(1);
		`CHK("hd_tx", 8'h0f, ssp_peer_inst.got[$])
		cfg(8'h00, 8'h00, 8'h00, 8'h01);
		reg_wr(ssp_pkg::A_TXD, 8'h96);
		slave_frame(1'b0, v);
		`CHK("slave_tx", 8'h96, v)
		wait_flag(1);
		cfg(8'h00, 8'h00, 8'h05, 8'h01);
		tb_cs_n <= 1'b0;
		reg_wr(ssp_pkg::A_TXD, 8'h5a);
		slave_frame(1'b1, v);
		`CHK("cs_in_oe", 1'b0, in_pad.oe_n)
		`CHK("cs_slave", 8'h5a, v)
		wait_flag(1);
		tally_and_finish;
	end
endmodule : test_clocked_serial_port_ops
`default_nettype wire
